// ===== core/fmc_top.v
// Frequency-measuring counter: times rising edges of the count input,
// turns the interval into a frequency word and keeps the process image.
// Assumes count_in and inhibit_in are asynchronous pins and that software
// reaches the image over the plain register port on sys_clk.
`timescale 1ns/1ns
`include "fmc_map.vh"

// Notes on behaviour
// - Time the span of rising count edges and derive the frequency.
// - Measurement runs only while the inhibit input is low; high suspends it.
// - Two switching outputs each follow their own control byte bit.
// - Compute and update on every 1st, 4th or 16th edge per range.
// - First edge only arms timing; data invalid until a period completes.
// - Static high or low count input reports the invalid marker.
// - With no transitions, force an invalid-marker update after timeout.
// - Image: 32-bit data word, control byte out, status byte in.
// - One-period range gives millihertz counts up to 8 kHz.
// - Four-period range gives centihertz counts up to 32 kHz.
// - Sixteen-period ranges give decihertz or hertz counts up to 100 kHz.
// - Range codes: 00 1p mHz, 01 4p cHz, 10 16p dHz, 11 16p Hz.
// - Acknowledge bits echo the range once a result completes for it, even one over range.
// - Timeout loads on request from OUTDATA low bits; masked, 10 s, echoed.
// - Result above the range maximum returns the invalid marker.
module fmc_top #(
  parameter CYC_PER_MS = `FMC_MS_NS / `FMC_CLK_NS
) (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        count_in,
  input  wire        inhibit_in,
  input  wire [7:0]  bus_addr,
  input  wire [31:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [31:0] bus_rdata,
  output reg         irq,
  output reg         switch_output_a,
  output reg         switch_output_b
);

  localparam S_IDLE = 1'b0;
  localparam S_MEAS = 1'b1;
  // Divider end count, cut to the 17-bit counter on purpose
  localparam integer MS_LAST_I = CYC_PER_MS - 1;
  localparam [16:0]  MS_LAST   = MS_LAST_I[16:0];

  // Synchronised pins and edge detect
  wire        count_s;
  wire        inhibit_pin_state;
  reg         count_d_r;
  wire        rise = count_s & ~count_d_r;

  // Process image and configuration
  reg  [7:0]  ctrl_r;
  reg  [31:0] out_data_r;
  reg  [31:0] in_data_r;
  reg  [1:0]  range_ack_r;
  reg  [1:0]  range_act_r;
  reg         timeout_change_echo_r;
  reg  [13:0] timeout_r;

  // Measurement state
  reg         state_r;
  reg  [31:0] per_cnt_r;
  reg  [4:0]  edge_cnt_r;
  reg  [1:0]  gen_r;
  reg  [1:0]  div_gen_r;
  reg  [1:0]  div_range_r;
  reg         div_start_r;
  reg  [39:0] div_num_r;
  reg  [31:0] div_den_r;
  wire        div_done;
  wire [39:0] div_q;

  // Watchdog timing
  reg  [16:0] ms_div_r;
  reg         ms_tick_r;
  reg  [13:0] wd_cnt_r;

  // Interrupts
  reg  [`FMC_IRQ_W-1:0] irq_stat_r;
  reg  [`FMC_IRQ_W-1:0] irq_mask_r;
  reg  [`FMC_IRQ_W-1:0] irq_set;

  // Range-dependent constants
  reg  [4:0]  edges_need;
  reg  [39:0] scale;
  reg  [39:0] limit_q;

  wire [1:0]  range_req   = ctrl_r[`FMC_CTRL_RANGE_HI:`FMC_CTRL_RANGE_LO];
  wire        treq        = ctrl_r[`FMC_CTRL_TREQ];
  wire        range_chg   = ~inhibit_pin_state & (range_req != range_act_r);
  wire        wd_fire     = ms_tick_r & (wd_cnt_r >= timeout_r);
  wire        div_valid   = div_done & (div_gen_r == gen_r);
  wire        overrange   = div_q > limit_q;
  wire        rd_stat     = bus_rd & (bus_addr == `FMC_ADDR_IRQ_STAT);
  wire [7:0]  status_byte = {2'b00, inhibit_pin_state,
                             timeout_change_echo_r, switch_output_b,
                             switch_output_a, range_ack_r};

  fmc_sync #(
    .W (2)
  ) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .din     ({inhibit_in, count_in}),
    .dout    ({inhibit_pin_state, count_s})
  );

  fmc_div u_div (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .start    (div_start_r),
    .dividend (div_num_r),
    .divisor  (div_den_r),
    .done     (div_done),
    .quotient (div_q)
  );

  // Periods per update and unit scale of the active range
  always @*
  begin
    case (range_act_r)
      `FMC_RANGE_1P_MHZ:
      begin
        edges_need = `FMC_EDGES_1P;
        scale      = `FMC_SCALE_R0;
      end
      `FMC_RANGE_4P_CHZ:
      begin
        edges_need = `FMC_EDGES_4P;
        scale      = `FMC_SCALE_R1;
      end
      `FMC_RANGE_16P_DHZ:
      begin
        edges_need = `FMC_EDGES_16P;
        scale      = `FMC_SCALE_R2;
      end
      default:
      begin
        edges_need = `FMC_EDGES_16P;
        scale      = `FMC_SCALE_R3;
      end
    endcase
  end

  // Ceiling of the range the result was computed for
  always @*
  begin
    case (div_range_r)
      `FMC_RANGE_1P_MHZ:  limit_q = `FMC_LIMIT_R0;
      `FMC_RANGE_4P_CHZ:  limit_q = `FMC_LIMIT_R1;
      `FMC_RANGE_16P_DHZ: limit_q = `FMC_LIMIT_R2;
      default:            limit_q = `FMC_LIMIT_R3;
    endcase
  end

  // Register writes; reserved control bits are forced to zero
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r     <= `FMC_CTRL_RST;
      out_data_r <= 32'h00000000;
      irq_mask_r <= {`FMC_IRQ_W{1'b0}};
    end
    else if (bus_wr)
    begin
      case (bus_addr)
        `FMC_ADDR_CTRL:     ctrl_r     <= bus_wdata[7:0] & `FMC_CTRL_WMASK;
        `FMC_ADDR_OUTDATA:  out_data_r <= bus_wdata;
        `FMC_ADDR_IRQ_MASK: irq_mask_r <= bus_wdata[`FMC_IRQ_W-1:0];
        default:            ;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped read zero
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      bus_rdata <= 32'h00000000;
    else if (bus_rd)
    begin
      case (bus_addr)
        `FMC_ADDR_CTRL:     bus_rdata <= {24'h000000, ctrl_r};
        `FMC_ADDR_OUTDATA:  bus_rdata <= out_data_r;
        `FMC_ADDR_INDATA:   bus_rdata <= in_data_r;
        `FMC_ADDR_STATUS:   bus_rdata <= {24'h000000, status_byte};
        `FMC_ADDR_IRQ_STAT: bus_rdata <= {28'h0000000, irq_stat_r};
        `FMC_ADDR_IRQ_MASK: bus_rdata <= {28'h0000000, irq_mask_r};
        default:            bus_rdata <= 32'h00000000;
      endcase
    end
    else
      bus_rdata <= 32'h00000000;
  end

  // Switching outputs follow the control byte one cycle later
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      switch_output_a <= 1'b0;
      switch_output_b <= 1'b0;
    end
    else
    begin
      switch_output_a <= ctrl_r[`FMC_CTRL_OUT_A];
      switch_output_b <= ctrl_r[`FMC_CTRL_OUT_B];
    end
  end

  // Timeout handshake: echo follows the request level, value loads on rise
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timeout_r             <= `FMC_TIMEOUT_DEF;
      timeout_change_echo_r <= 1'b0;
    end
    else if (treq & ~timeout_change_echo_r)
    begin
      timeout_r             <= out_data_r[13:0] & `FMC_TIMEOUT_MASK;
      timeout_change_echo_r <= 1'b1;
    end
    else if (~treq)
      timeout_change_echo_r <= 1'b0;
  end

  // Millisecond enable pulse from a free-running divider
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ms_div_r  <= 17'h00000;
      ms_tick_r <= 1'b0;
    end
    else if (ms_div_r == MS_LAST)
    begin
      ms_div_r  <= 17'h00000;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      ms_div_r  <= ms_div_r + 17'h00001;
      ms_tick_r <= 1'b0;
    end
  end

  // Watchdog counts whole ms since the last update; held while inhibited.
  // The first ms is partial, so the forced update may come up to 1 ms late.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      wd_cnt_r <= 14'h0000;
    else if (div_valid | wd_fire | range_chg)
      wd_cnt_r <= 14'h0000;
    else if (ms_tick_r & ~inhibit_pin_state & (wd_cnt_r != 14'h3FFF))
      wd_cnt_r <= wd_cnt_r + 14'h0001;
  end

  // Edge detector reads only the synchronised copy
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      count_d_r <= 1'b0;
    else
      count_d_r <= count_s;
  end

  // Measurement sequencer: first edge arms, later edges close intervals.
  // Intervals keep running while the divider works, so no edge is missed.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= S_IDLE;
      per_cnt_r   <= 32'h00000000;
      edge_cnt_r  <= 5'h00;
      gen_r       <= 2'h0;
      div_gen_r   <= 2'h0;
      div_range_r <= 2'h0;
      div_start_r <= 1'b0;
      div_num_r   <= 40'h0000000000;
      div_den_r   <= 32'h00000001;
      range_act_r <= 2'h0;
    end
    else
    begin
      div_start_r <= 1'b0;
      if (inhibit_pin_state)
      begin
        state_r <= S_IDLE;
        gen_r   <= gen_r + 2'h1;
      end
      else if (range_chg | wd_fire)
      begin
        // Restart timing; a result still in flight is discarded by gen_r
        range_act_r <= range_req;
        state_r     <= S_IDLE;
        gen_r       <= gen_r + 2'h1;
      end
      else
      begin
        case (state_r)
          S_IDLE:
          begin
            if (rise)
            begin
              state_r    <= S_MEAS;
              per_cnt_r  <= 32'h00000000;
              edge_cnt_r <= 5'h00;
            end
          end
          S_MEAS:
          begin
            if (per_cnt_r != 32'hFFFFFFFF)
              per_cnt_r <= per_cnt_r + 32'h00000001;
            if (rise)
            begin
              if (edge_cnt_r + 5'h01 == edges_need)
              begin
                div_start_r <= 1'b1;
                div_num_r   <= `FMC_CLK_HZ * scale;
                div_den_r   <= per_cnt_r + 32'h00000001;
                div_gen_r   <= gen_r;
                div_range_r <= range_act_r;
                per_cnt_r   <= 32'h00000000;
                edge_cnt_r  <= 5'h00;
              end
              else
                edge_cnt_r <= edge_cnt_r + 5'h01;
            end
          end
          default:
            state_r <= S_IDLE;
        endcase
      end
    end
  end

  // Input data word and range acknowledge
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_data_r   <= `FMC_INVALID;
      range_ack_r <= 2'h0;
    end
    else if (inhibit_pin_state)
      in_data_r <= in_data_r;
    else if (range_chg)
      in_data_r <= `FMC_INVALID;
    else if (wd_fire)
      in_data_r <= `FMC_INVALID;
    else if (div_valid)
    begin
      if (overrange)
        in_data_r <= `FMC_INVALID;
      else
        in_data_r <= div_q[31:0];
      range_ack_r <= div_range_r;
    end
  end

  // Events that set sticky interrupt bits
  always @*
  begin
    irq_set = {`FMC_IRQ_W{1'b0}};
    irq_set[`FMC_IRQ_UPDATE]    = div_valid & ~inhibit_pin_state & ~range_chg
                                  & ~wd_fire;
    irq_set[`FMC_IRQ_FORCED]    = wd_fire & ~inhibit_pin_state & ~range_chg;
    irq_set[`FMC_IRQ_TIMEOUT]   = treq & ~timeout_change_echo_r;
    irq_set[`FMC_IRQ_OVERRANGE] = irq_set[`FMC_IRQ_UPDATE] & overrange;
  end

  // Read clears, but an event in the same cycle wins over the clear
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_stat_r <= {`FMC_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end
    else
    begin
      if (rd_stat)
        irq_stat_r <= irq_set;
      else
        irq_stat_r <= irq_stat_r | irq_set;
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

// ===== include/fmc_map.vh
// Constants of the frequency-measuring counter: offsets, fields, resets,
// timing. Assumes a 125 MHz system clock and a byte-addressed register port.
`ifndef FMC_MAP_VH
`define FMC_MAP_VH

// Register byte addresses
`define FMC_ADDR_CTRL      8'h00
`define FMC_ADDR_OUTDATA   8'h04
`define FMC_ADDR_INDATA    8'h08
`define FMC_ADDR_STATUS    8'h0C
`define FMC_ADDR_IRQ_STAT  8'h10
`define FMC_ADDR_IRQ_MASK  8'h14

// Control byte fields
`define FMC_CTRL_RANGE_LO  0
`define FMC_CTRL_RANGE_HI  1
`define FMC_CTRL_OUT_A     2
`define FMC_CTRL_OUT_B     3
`define FMC_CTRL_TREQ      4
`define FMC_CTRL_WMASK     8'h1F

// Status byte fields
`define FMC_STAT_ECHO      4
`define FMC_STAT_INHIBIT   5

// Interrupt status bits
`define FMC_IRQ_UPDATE     0
`define FMC_IRQ_FORCED     1
`define FMC_IRQ_TIMEOUT    2
`define FMC_IRQ_OVERRANGE  3
`define FMC_IRQ_W          4

// Reset values and markers
`define FMC_INVALID        32'hFFFFFFFF
`define FMC_TIMEOUT_MASK   14'h3FFF
`define FMC_TIMEOUT_DEF    14'h2710
`define FMC_CTRL_RST       8'h00

// Timing: clock period and one millisecond, both in ns
`define FMC_CLK_NS         8
`define FMC_MS_NS          1000000
`define FMC_CLK_HZ         40'h0007735940

// Range codes, periods per update and result scale per range
`define FMC_RANGE_1P_MHZ   2'h0
`define FMC_RANGE_4P_CHZ   2'h1
`define FMC_RANGE_16P_DHZ  2'h2
`define FMC_RANGE_16P_HZ   2'h3
`define FMC_EDGES_1P       5'h01
`define FMC_EDGES_4P       5'h04
`define FMC_EDGES_16P      5'h10
`define FMC_SCALE_R0       40'h00000003E8
`define FMC_SCALE_R1       40'h0000000190
`define FMC_SCALE_R2       40'h00000000A0
`define FMC_SCALE_R3       40'h0000000010

// Highest result per range: 8 kHz, 32 kHz, 100 kHz in range units
`define FMC_LIMIT_R0       40'h00007A1200
`define FMC_LIMIT_R1       40'h000030D400
`define FMC_LIMIT_R2       40'h00000F4240
`define FMC_LIMIT_R3       40'h00000186A0

`endif

// ===== core/fmc_sync.v
// Two-flop synchroniser for pins that arrive from outside sys_clk.
// Assumes the caller reads only dout; the first stage feeds nothing else.
`timescale 1ns/1ns
module fmc_sync #(
  parameter W = 1
) (
  input  wire         sys_clk,
  input  wire         resetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta_r;

  // First stage may go metastable; only the second stage reads it
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

// ===== core/fmc_div.v
// Restoring divider, 40-bit dividend by 32-bit divisor, one bit per cycle.
// Assumes start is a one-cycle pulse and the divisor is never zero.
`timescale 1ns/1ns
module fmc_div (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        start,
  input  wire [39:0] dividend,
  input  wire [31:0] divisor,
  output reg         done,
  output reg  [39:0] quotient
);

  reg  [31:0] rem_r;
  reg  [31:0] dsr_r;
  reg  [5:0]  cnt_r;
  reg         busy_r;
  wire [32:0] shifted = {rem_r, quotient[39]};
  wire [32:0] diff    = shifted - {1'b0, dsr_r};

  // Forty steps; a new start restarts the division from scratch
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rem_r    <= 32'h00000000;
      dsr_r    <= 32'h00000000;
      quotient <= 40'h0000000000;
      cnt_r    <= 6'h00;
      busy_r   <= 1'b0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        rem_r    <= 32'h00000000;
        dsr_r    <= divisor;
        quotient <= dividend;
        cnt_r    <= 6'h28;
        busy_r   <= 1'b1;
      end
      else if (busy_r)
      begin
        if (!diff[32])
        begin
          rem_r    <= diff[31:0];
          quotient <= {quotient[38:0], 1'b1};
        end
        else
        begin
          rem_r    <= shifted[31:0];
          quotient <= {quotient[38:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01)
        begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== testbench/fmc_top_asserts.sv
// Port checker for the frequency counter, bound into fmc_top.
// Assumes one clock, sys_clk, and resetn low as the only reset.
`timescale 1ns/1ns
`include "fmc_map.vh"
module fmc_top_asserts #(
  parameter CYC_PER_MS = 125000
) (
  input wire        sys_clk,
  input wire        resetn,
  input wire        count_in,
  input wire        inhibit_in,
  input wire [7:0]  bus_addr,
  input wire [31:0] bus_wdata,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [31:0] bus_rdata,
  input wire        irq,
  input wire        switch_output_a,
  input wire        switch_output_b
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Read data show only in the slot after a read strobe
  property p_rdata_idle;
    bus_rdata != 32'h0 |-> $past(bus_rd);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its slot");

  // Switch outputs follow a control write two edges later
  property p_sw_a;
    bus_wr && bus_addr == `FMC_ADDR_CTRL |=> ##1
      switch_output_a == $past(bus_wdata[2], 2);
  endproperty
  a_sw_a: assert property (p_sw_a)
    else $error("switch a does not follow control");
  property p_sw_b;
    bus_wr && bus_addr == `FMC_ADDR_CTRL |=> ##1
      switch_output_b == $past(bus_wdata[3], 2);
  endproperty
  a_sw_b: assert property (p_sw_b)
    else $error("switch b does not follow control");

  // Outputs move only as the result of a control write
  property p_sw_hold;
    $changed(switch_output_a) || $changed(switch_output_b) |->
      $past(bus_wr, 2) && $past(bus_addr, 2) == `FMC_ADDR_CTRL;
  endproperty
  a_sw_hold: assert property (p_sw_hold)
    else $error("switch output moved without write");

  // Unmapped space above 0x14 reads as zero
  property p_unmapped;
    bus_rd && bus_addr > 8'h14 |=> bus_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // Control byte keeps only five bits
  property p_ctrl_width;
    bus_rd && bus_addr == `FMC_ADDR_CTRL |=> bus_rdata[31:5] == 27'h0;
  endproperty
  a_ctrl_width: assert property (p_ctrl_width)
    else $error("control upper bits set");

  // Status byte stays within six bits
  property p_stat_width;
    bus_rd && bus_addr == `FMC_ADDR_STATUS |=> bus_rdata[31:6] == 26'h0;
  endproperty
  a_stat_width: assert property (p_stat_width)
    else $error("status upper bits set");

  // Settled inhibit pin shows in the status byte
  property p_inhibit;
    $stable(inhibit_in) [*5] ##0 (bus_rd && bus_addr == `FMC_ADDR_STATUS)
      |=> bus_rdata[5] == $past(inhibit_in);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit state wrong in status");

  // A cleared mask silences the interrupt line
  property p_irq_mask;
    (bus_wr && bus_addr == `FMC_ADDR_IRQ_MASK && bus_wdata[3:0] == 4'h0)
      ##1 !(bus_wr && bus_addr == `FMC_ADDR_IRQ_MASK) |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq high with mask cleared");
endmodule

bind fmc_top fmc_top_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .count_in(count_in),
  .inhibit_in(inhibit_in), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
  .switch_output_a(switch_output_a), .switch_output_b(switch_output_b)
);

// ===== testbench/fmc_pulse_src.sv
// Pulse source standing in for the field signal at the count pin.
// Assumes the period is a whole number of sys_clk cycles, 2 * half.
`timescale 1ns/1ns
module fmc_pulse_src (
  input  wire        sys_clk,
  input  wire        run,
  input  wire [15:0] half,
  output logic       count_out
);
  logic [15:0] cnt;

  initial
  begin
    cnt = 16'h0000;
    count_out = 1'b0;
  end

  // Stopped source sits low, a static level the counter must flag
  always @(posedge sys_clk)
    if (!run)
    begin
      cnt <= 16'h0000;
      count_out <= 1'b0;
    end
    else if (cnt + 16'h0001 >= half)
    begin
      cnt <= 16'h0000;
      count_out <= ~count_out;
    end
    else
      cnt <= cnt + 16'h0001;
endmodule

// ===== testbench/fmc_top_tb_top.sv
// Self-checking bench for the frequency counter.
// Assumes the checker is bound in and a 50-cycle millisecond tick.
`timescale 1ns/1ns
`include "fmc_map.vh"
module fmc_top_tb_top;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        inhibit_in = 1'b0;
  logic [7:0]  bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        src_run = 1'b0;
  logic [15:0] src_half = 16'h0032;
  logic [31:0] rnd = 32'h0000005A;
  logic [31:0] e, m;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  wire         count_in, irq, sw_a, sw_b;
  wire  [31:0] bus_rdata;
  integer      n_errors = 0;
  integer      n_checks = 0;
  integer      r;

  always #4 sys_clk = ~sys_clk;

  fmc_top #(.CYC_PER_MS(50)) uut (
    .sys_clk(sys_clk), .resetn(resetn), .count_in(count_in),
    .inhibit_in(inhibit_in), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
    .switch_output_a(sw_a), .switch_output_b(sw_b)
  );
  fmc_pulse_src u_src (
    .sys_clk(sys_clk), .run(src_run), .half(src_half), .count_out(count_in)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic idle(input integer n);
    // Returns on the edge so that callers drive inputs there
    repeat (n) @(posedge sys_clk);
  endtask

  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask

  // Expected value is queued; the monitor compares it a cycle later
  task automatic rd(input logic [7:0] a, input logic [31:0] x, k);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    q_exp.push_back(x);
    q_msk.push_back(k);
    @(posedge sys_clk);
    bus_rd <= 1'b0;
  endtask

  task automatic wait_irq(input integer lim);
    integer i;
    for (i = 0; i < lim && irq !== 1'b1; i++)
      idle(1);
    check("irq raised", {31'h0, irq}, 32'h1);
    if (irq !== 1'b1)
      test_done;
  endtask

  // Read data stand only in the slot after the strobe
  always @(posedge sys_clk)
  begin
    if (rd_q)
    begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      check("bus_rdata", bus_rdata & m, e & m);
    end
    rd_q <= bus_rd;
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`FMC_ADDR_CTRL, 32'h0, 32'hFF);
    rd(`FMC_ADDR_STATUS, 32'h0, 32'hFF);
    rd(`FMC_ADDR_INDATA, `FMC_INVALID, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    // One period of 20000 cycles gives 6.25 kHz in millihertz
    wr(`FMC_ADDR_IRQ_MASK, 32'h9);
    rd(`FMC_ADDR_IRQ_STAT, 32'h0, 32'hF);
    src_half <= 16'h2710;
    src_run <= 1'b1;
    wait_irq(45000);
    src_run <= 1'b0;
    rd(`FMC_ADDR_INDATA, 32'h005F5E10, 32'hFFFFFFFF);
    rd(`FMC_ADDR_STATUS, 32'h0, 32'h3);
    rd(`FMC_ADDR_IRQ_STAT, 32'h1, 32'h1);
    $display("test range 0 done");
    // A fast input overruns every longer range
    for (r = 1; r < 4; r++)
    begin
      wr(`FMC_ADDR_CTRL, {rnd[31:8], 8'h00} | r);
      rnd = lfsr(rnd);
      idle(4);
      rd(`FMC_ADDR_INDATA, `FMC_INVALID, 32'hFFFFFFFF);
      rd(`FMC_ADDR_IRQ_STAT, 32'h0, 32'hF);
      src_half <= 16'h0032;
      src_run <= 1'b1;
      wait_irq(3000);
      src_run <= 1'b0;
      rd(`FMC_ADDR_INDATA, `FMC_INVALID, 32'hFFFFFFFF);
      rd(`FMC_ADDR_STATUS, r, 32'h3);
      rd(`FMC_ADDR_IRQ_STAT, 32'h8, 32'h8);
    end
    $display("test ranges done");
    // Inhibit holds back updates until released
    idle(100);
    rd(`FMC_ADDR_IRQ_STAT, 32'h0, 32'hF);
    inhibit_in <= 1'b1;
    idle(5);
    src_run <= 1'b1;
    idle(2000);
    check("irq inhibited", {31'h0, irq}, 32'h0);
    rd(`FMC_ADDR_STATUS, 32'h20, 32'h20);
    inhibit_in <= 1'b0;
    wait_irq(3000);
    src_run <= 1'b0;
    $display("test inhibit done");
    // Bits 7..5 are dropped; outputs follow bits 2 and 3
    for (r = 0; r < 4; r++)
    begin
      wr(`FMC_ADDR_CTRL, 32'hE3 | (r << 2));
      idle(2);
      check("switch a", {31'h0, sw_a}, r & 1);
      check("switch b", {31'h0, sw_b}, (r >> 1) & 1);
      rd(`FMC_ADDR_CTRL, 32'h3 | (r << 2), 32'hFF);
      rd(`FMC_ADDR_STATUS, r << 2, 32'hC);
    end
    $display("test switches done");
    // Timeout of 5 ms hidden under random upper bits
    rnd = lfsr(rnd);
    wr(`FMC_ADDR_OUTDATA, {rnd[31:14], 14'h0005});
    rd(`FMC_ADDR_OUTDATA, {rnd[31:14], 14'h0005}, 32'hFFFFFFFF);
    wr(`FMC_ADDR_IRQ_MASK, 32'hF);
    wr(`FMC_ADDR_CTRL, 32'h10);
    idle(2);
    rd(`FMC_ADDR_STATUS, 32'h10, 32'h10);
    rd(`FMC_ADDR_IRQ_STAT, 32'h4, 32'h4);
    wr(`FMC_ADDR_CTRL, 32'h0);
    idle(2);
    rd(`FMC_ADDR_STATUS, 32'h0, 32'h10);
    wait_irq(400);
    rd(`FMC_ADDR_IRQ_STAT, 32'h2, 32'h2);
    rd(`FMC_ADDR_INDATA, `FMC_INVALID, 32'hFFFFFFFF);
    wr(`FMC_ADDR_IRQ_MASK, 32'h0);
    idle(3);
    check("irq masked", {31'h0, irq}, 32'h0);
    $display("test watchdog done");
    test_done;
  end
endmodule
